// ---- include/gts_consts.svh ----
// Constants for the guest table switch and fault block.
// Included by the design modules and tb_top; definitions only.
`ifndef GTS_CONSTS_SVH
`define GTS_CONSTS_SVH
// ********
// Register byte offsets
// ********
`define A_PRIM 8'h00
`define A_SEC 8'h04
`define A_FUNC_LO 8'h08
`define A_FUNC_HI 8'h0c
`define A_LIST_BASE 8'h10
`define A_SELECTOR 8'h14
`define A_INDEX 8'h18
`define A_ILEN 8'h1c
`define A_OPT 8'h20
`define A_ROOT_LO 8'h24
`define A_ROOT_HI 8'h28
`define A_ENTRY_LO 8'h2c
`define A_ENTRY_HI 8'h30
`define A_ENTRY_KIND 8'h34
`define A_INFO_BASE 8'h38
`define A_VP_TAG 8'h3c
`define A_PC_TAG 8'h40
`define A_CMD 8'h44
`define A_STATUS 8'h48
`define A_EXIT_REASON 8'h4c
`define A_EXIT_LEN 8'h50
`define A_PTR_INDEX 8'h54
// ********
// Field positions and values
// ********
`define CMD_FN 0
`define CMD_VIO 1
`define CMD_INV 2
`define KIND_LEAF 0
`define KIND_UNSUP 1
`define PRIM_SEC_BIT 31
`define SEC_VMF_BIT 13
`define SEL_MAX 32'h0000003f
`define SEL_SWITCH 32'h00000000
`define LIST_LEN 32'h00000200
`define ENTRY_SHIFT 3
`define HI_OFS 32'h00000004
`define EXIT_GUEST_FUNCTION_INSTR 32'h0000003b
`define EXIT_VIOL 32'h00000030
`define VE_VECTOR 8'h14
`define INFO_MARK 32'h00ffffff
`define INFO_MARK_OFS 32'h00000004
`define INFO_IDX_OFS 32'h00000020
`define VP_NONE 16'h0000
`define PC_NONE 12'h000
`define AD_BIT 6
`define FRAME_HI 51
`define FRAME_LO 12
`define PRESENT_MSB 2
`define PAGE_BIT 7
`define SUPPRESS_BIT 63
`define MT_UC 3'h0
`define MT_WB 3'h6
`define WALK_4 3'h3
`endif

// ---- include/gts_pkg.sv ----
// Types for the guest table switch and fault block.
// Assumes nothing beyond the constants header.
package gts_pkg;
    // ********
    // Enumerations
    // ********
    typedef enum logic [2:0] {
        ST_IDLE, ST_RD_LO, ST_RD_HI, ST_CHECK,
        ST_INFO_RD, ST_WR_REASON, ST_WR_INDEX, ST_WR_MARK
    } fsm_t;
    typedef enum logic [2:0] {
        OUT_NONE, OUT_UD, OUT_EXIT, OUT_SWITCH, OUT_VE, OUT_MISCONF
    } outcome_t;
    // ********
    // Carriers
    // ********
    typedef struct packed {
        logic ve_support;
        logic process_context_tag_en;
        logic lma;
        logic pae;
        logic idt_busy;
        logic prot_en;
        logic non_root;
        logic ve_ctrl;
        logic virtual_processor_tag_en;
    } opt_t;
    typedef struct packed {
        logic walk;
        logic inval;
        logic resume;
        logic ve;
        logic exit;
        logic ud;
    } pulse_t;
    typedef struct packed {
        logic req;
        logic we;
        logic [31:0] addr;
        logic [31:0] wdata;
    } mem_req_t;
    typedef struct packed {
        logic ack;
        logic [31:0] rdata;
    } mem_rsp_t;
    typedef struct packed {
        fsm_t state;
        logic [31:0] prim;
        logic [31:0] sec;
        logic [63:0] func;
        logic [31:0] list_base;
        logic [31:0] selector;
        logic [31:0] index;
        logic [3:0] ilen;
        opt_t opt;
        logic [63:0] root;
        logic [63:0] entry;
        logic [1:0] kind;
        logic [31:0] info_base;
        logic [15:0] vp;
        logic [11:0] pc;
        outcome_t outcome;
        logic stale;
        logic clear_seen;
        logic [39:0] last_frame;
        logic [31:0] exit_reason;
        logic [3:0] exit_len;
        logic [15:0] ptr_index;
        logic [63:0] tent;
        logic a_act;
        logic a_wr;
        logic [7:0] a_addr;
        pulse_t pulse;
    } state_t;
endpackage

// ---- verilog/func_gate.sv ----
// Guest function gate: fault, disabled-function exit and pointer check.
// Pure combinational; fed from the main block's registers.
`include "gts_consts.svh"
module func_gate (
    input wire logic [31:0] prim,
    input wire logic [31:0] sec,
    input wire logic [63:0] func,
    input wire logic [31:0] sel,
    input wire logic [63:0] ptr,
    output logic ud,
    output logic off_exit,
    output logic ptr_ok
);
    import gts_pkg::*;
    logic enabled;

    // ********
    // Pointer acceptance
    // ********
    function automatic logic ptr_valid(input logic [63:0] p);
        logic mt_ok;
        mt_ok = (p[2:0] == `MT_UC) || (p[2:0] == `MT_WB);
        return mt_ok && (p[5:3] == `WALK_4) && (p[11:7] == 5'h00) && (p[63:52] == 12'h000);
    endfunction

    always_comb begin
        // R3: secondary gate
        enabled = prim[`PRIM_SEC_BIT] && sec[`SEC_VMF_BIT];
        // R1: fault then exit
        ud = !enabled || (sel > `SEL_MAX);
        off_exit = !ud && !func[sel[5:0]];
        // R6: entry acceptance
        ptr_ok = ptr_valid(ptr);
    end
endmodule

// ---- verilog/violation_judge.sv ----
// Decides how a translation violation on one entry is handled.
// Pure combinational; entry and conditions come from registers.
`include "gts_consts.svh"
module violation_judge (
    input wire logic [63:0] entry,
    input wire logic leaf,
    input wire logic unsup,
    input wire gts_pkg::opt_t opt,
    output logic misconf,
    output logic conv_ok
);
    import gts_pkg::*;
    logic absent;
    logic maps;
    logic conv;

    always_comb begin
        // R19: not present entry
        absent = (entry[`PRESENT_MSB:0] == 3'h0);
        // R20: unsupported value
        misconf = !absent && unsup;
        // R21: mapping entries only
        maps = leaf || entry[`PAGE_BIT];
        // R18: control gates conversion
        conv = opt.ve_ctrl && !misconf && (absent || maps) && !entry[`SUPPRESS_BIT];
        // R22: conversion conditions
        // R17: guest operation only
        conv_ok = conv && opt.prot_en && !opt.idt_busy && opt.non_root;
    end
endmodule

// ---- verilog/guest_table_switch_fault.sv ----
// Guest function root switch and violation-to-fault conversion.
// AHB-Lite slave, zero wait states; 32-bit memory port with ack.
`include "gts_consts.svh"
// Function
// R1: Fault when functions disabled or selector above 63, else exit if disabled.
// R2: Root switch is function zero, enabled by control bit 0.
// R3: Functions count as disabled when primary control bit 31 clear.
// R4: Index of 512 or more exits without reading the list.
// R5: Fetch 8-byte pointer at list base plus eight times index.
// R6: Unacceptable fetched pointer causes exit, no switch.
// R7: Acceptable pointer is stored and used for later translation.
// R8: With conversion support, store index low 16 bits as pointer index.
// R9: General registers and flags never changed by the switch.
// R10: Switch exits report reason 59 and instruction length only.
// R11: Resume at next instruction; tags use new frame, current tags.
// R12: Tagging off: invalidate tag 0000H mappings on success.
// R13: Disabled tagging uses tags 0000H and 000H.
// R14: No exit for base address; flat or long paging rewalks it.
// R15: Address-extension paging keeps directory pointers, no reload.
// R16: Bit 6 enables flag updates; may miss without prior invalidate.
// R17: Fault uses vector 20, only in guest operation.
// R18: Conversion control clear makes every violation exit.
// R19: Entry bits 2:0 zero is absent; convertible iff bit 63 zero.
// R20: Present unsupported entry is misconfiguration; always exits.
// R21: Mapping entries decide by bit 63; table references ignored.
// R22: Convert only with protection on, no delivery, info word zero.
// R23: Save fault information first, then deliver the fault.
// R24: Delivery writes FFFFFFH at offset 4; software clears it.
// R25: Failed conversion conditions fall back to exit, info untouched.
module guest_table_switch_fault (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    output gts_pkg::mem_req_t mem_req,
    input wire gts_pkg::mem_rsp_t mem_rsp,
    output logic ud_fault,
    output logic vm_exit,
    output logic ve_fault,
    output logic [7:0] ve_vector,
    output logic tlb_inval,
    output logic base_walk,
    output logic resume_next,
    output logic [39:0] tag_frame,
    output logic [15:0] tag_vp,
    output logic [11:0] tag_pc
);
    import gts_pkg::*;
    state_t r;
    state_t n;
    logic wr;
    logic cmd_fn;
    logic cmd_vio;
    logic cmd_inv;
    logic g_ud;
    logic g_off;
    logic g_ok;
    logic j_misconf;
    logic j_conv_ok;

    // ********
    // Helpers
    // ********
    function automatic state_t take_exit(input state_t s, input logic [31:0] reason, input logic [3:0] len);
        state_t t;
        t = s;
        t.pulse.exit = 1'b1;
        t.outcome = OUT_EXIT;
        t.exit_reason = reason;
        t.exit_len = len;
        t.state = ST_IDLE;
        return t;
    endfunction

    func_gate u_gate (
        .prim(r.prim),
        .sec(r.sec),
        .func(r.func),
        .sel(r.selector),
        .ptr(r.tent),
        .ud(g_ud),
        .off_exit(g_off),
        .ptr_ok(g_ok)
    );

    violation_judge u_judge (
        .entry(r.entry),
        .leaf(r.kind[`KIND_LEAF]),
        .unsup(r.kind[`KIND_UNSUP]),
        .opt(r.opt),
        .misconf(j_misconf),
        .conv_ok(j_conv_ok)
    );

    // ********
    // Next state
    // ********
    always_comb begin
        n = r;
        n.pulse = '0;
        wr = ce && r.a_act && r.a_wr;
        cmd_fn = wr && (r.a_addr == `A_CMD) && hwdata[`CMD_FN] && (r.state == ST_IDLE);
        cmd_vio = wr && (r.a_addr == `A_CMD) && hwdata[`CMD_VIO] && !hwdata[`CMD_FN] && (r.state == ST_IDLE);
        cmd_inv = wr && (r.a_addr == `A_CMD) && hwdata[`CMD_INV];
        n.a_act = hsel && htrans[1] && hready;
        n.a_wr = hwrite;
        n.a_addr = haddr[7:0];
        if (wr) begin
            if (r.a_addr == `A_PRIM) begin
                n.prim = hwdata;
            end else if (r.a_addr == `A_SEC) begin
                n.sec = hwdata;
            end else if (r.a_addr == `A_FUNC_LO) begin
                n.func[31:0] = hwdata;
            end else if (r.a_addr == `A_FUNC_HI) begin
                n.func[63:32] = hwdata;
            end else if (r.a_addr == `A_LIST_BASE) begin
                n.list_base = hwdata;
            end else if (r.a_addr == `A_SELECTOR) begin
                n.selector = hwdata;
            end else if (r.a_addr == `A_INDEX) begin
                n.index = hwdata;
            end else if (r.a_addr == `A_ILEN) begin
                n.ilen = hwdata[3:0];
            end else if (r.a_addr == `A_OPT) begin
                n.opt = hwdata[8:0];
            end else if (r.a_addr == `A_ROOT_LO) begin
                n.root[31:0] = hwdata;
            end else if (r.a_addr == `A_ROOT_HI) begin
                n.root[63:32] = hwdata;
            end else if (r.a_addr == `A_ENTRY_LO) begin
                n.entry[31:0] = hwdata;
            end else if (r.a_addr == `A_ENTRY_HI) begin
                n.entry[63:32] = hwdata;
            end else if (r.a_addr == `A_ENTRY_KIND) begin
                n.kind = hwdata[1:0];
            end else if (r.a_addr == `A_INFO_BASE) begin
                n.info_base = hwdata;
            end else if (r.a_addr == `A_VP_TAG) begin
                n.vp = hwdata[15:0];
            end else if (r.a_addr == `A_PC_TAG) begin
                n.pc = hwdata[11:0];
            end
        end
        if (cmd_inv) begin
            n.clear_seen = 1'b0;
            n.stale = 1'b0;
        end
        // R9: only block state touched
        case (r.state)
            ST_IDLE: begin
                if (cmd_fn) begin
                    // R1: fault before exit
                    if (g_ud) begin
                        n.pulse.ud = 1'b1;
                        n.outcome = OUT_UD;
                    // R2: only function zero switches
                    // R4: bound before any read
                    end else if (g_off || (r.selector != `SEL_SWITCH) || (r.index >= `LIST_LEN)) begin
                        n = take_exit(n, `EXIT_GUEST_FUNCTION_INSTR, r.ilen);
                    end else begin
                        n.state = ST_RD_LO;
                    end
                end else if (cmd_vio) begin
                    // R20: misconfiguration exits
                    if (j_misconf) begin
                        n.pulse.exit = 1'b1;
                        n.outcome = OUT_MISCONF;
                    end else if (j_conv_ok) begin
                        n.state = ST_INFO_RD;
                    end else begin
                        n = take_exit(n, `EXIT_VIOL, 4'h0);
                    end
                end
            end
            ST_RD_LO: begin
                if (mem_rsp.ack) begin
                    n.tent[31:0] = mem_rsp.rdata;
                    n.state = ST_RD_HI;
                end
            end
            ST_RD_HI: begin
                if (mem_rsp.ack) begin
                    n.tent[63:32] = mem_rsp.rdata;
                    n.state = ST_CHECK;
                end
            end
            ST_CHECK: begin
                if (!g_ok) begin
                    // R10: switch exit reporting
                    n = take_exit(n, `EXIT_GUEST_FUNCTION_INSTR, r.ilen);
                end else begin
                    // R7: install new root
                    n.root = r.tent;
                    n.outcome = OUT_SWITCH;
                    n.state = ST_IDLE;
                    // R8: pointer index copy
                    if (r.opt.ve_support) begin
                        n.ptr_index = r.index[15:0];
                    end
                    // R11: continue next instruction
                    n.pulse.resume = 1'b1;
                    // R12: untagged invalidate
                    n.pulse.inval = !r.opt.virtual_processor_tag_en;
                    // R14: rewalk base, no exit
                    // R15: directory pointers kept
                    n.pulse.walk = !r.opt.pae || r.opt.lma;
                    // R16: flag update hazard
                    if (!r.tent[`AD_BIT]) begin
                        n.clear_seen = 1'b1;
                        n.last_frame = r.tent[`FRAME_HI:`FRAME_LO];
                    end else if (r.clear_seen && (r.last_frame == r.tent[`FRAME_HI:`FRAME_LO])) begin
                        n.stale = 1'b1;
                    end
                end
            end
            ST_INFO_RD: begin
                if (mem_rsp.ack) begin
                    // R25: busy info area falls back
                    if (mem_rsp.rdata != 32'h00000000) begin
                        n = take_exit(n, `EXIT_VIOL, 4'h0);
                    end else begin
                        n.state = ST_WR_REASON;
                    end
                end
            end
            ST_WR_REASON: begin
                if (mem_rsp.ack) begin
                    n.state = ST_WR_INDEX;
                end
            end
            ST_WR_INDEX: begin
                if (mem_rsp.ack) begin
                    n.state = ST_WR_MARK;
                end
            end
            ST_WR_MARK: begin
                if (mem_rsp.ack) begin
                    // R23: deliver after saving
                    n.pulse.ve = 1'b1;
                    n.outcome = OUT_VE;
                    n.state = ST_IDLE;
                end
            end
            default: begin
                n.state = ST_IDLE;
            end
        endcase
    end

    // ********
    // State register
    // ********
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            r <= '0;
        end else if (ce) begin
            r <= n;
        end
    end

    // ********
    // Memory port
    // ********
    always_comb begin
        mem_req = '0;
        mem_req.req = ce && (r.state != ST_IDLE) && (r.state != ST_CHECK);
        case (r.state)
            ST_RD_LO: begin
                // R5: list entry address
                mem_req.addr = r.list_base + (r.index << `ENTRY_SHIFT);
            end
            ST_RD_HI: begin
                mem_req.addr = r.list_base + (r.index << `ENTRY_SHIFT) + `HI_OFS;
            end
            ST_INFO_RD: begin
                // R22: info word check
                mem_req.addr = r.info_base + `INFO_MARK_OFS;
            end
            ST_WR_REASON: begin
                mem_req.we = 1'b1;
                mem_req.addr = r.info_base;
                mem_req.wdata = `EXIT_VIOL;
            end
            ST_WR_INDEX: begin
                mem_req.we = 1'b1;
                mem_req.addr = r.info_base + `INFO_IDX_OFS;
                mem_req.wdata = {16'h0000, r.ptr_index};
            end
            ST_WR_MARK: begin
                // R24: marker word
                mem_req.we = 1'b1;
                mem_req.addr = r.info_base + `INFO_MARK_OFS;
                mem_req.wdata = `INFO_MARK;
            end
            default: begin
                mem_req.addr = 32'h00000000;
            end
        endcase
    end

    // ********
    // Bus read data
    // ********
    always_comb begin
        if (r.a_addr == `A_PRIM) begin
            hrdata = r.prim;
        end else if (r.a_addr == `A_SEC) begin
            hrdata = r.sec;
        end else if (r.a_addr == `A_FUNC_LO) begin
            hrdata = r.func[31:0];
        end else if (r.a_addr == `A_FUNC_HI) begin
            hrdata = r.func[63:32];
        end else if (r.a_addr == `A_LIST_BASE) begin
            hrdata = r.list_base;
        end else if (r.a_addr == `A_SELECTOR) begin
            hrdata = r.selector;
        end else if (r.a_addr == `A_INDEX) begin
            hrdata = r.index;
        end else if (r.a_addr == `A_ILEN) begin
            hrdata = {28'h0000000, r.ilen};
        end else if (r.a_addr == `A_OPT) begin
            hrdata = {23'h0, r.opt};
        end else if (r.a_addr == `A_ROOT_LO) begin
            hrdata = r.root[31:0];
        end else if (r.a_addr == `A_ROOT_HI) begin
            hrdata = r.root[63:32];
        end else if (r.a_addr == `A_ENTRY_LO) begin
            hrdata = r.entry[31:0];
        end else if (r.a_addr == `A_ENTRY_HI) begin
            hrdata = r.entry[63:32];
        end else if (r.a_addr == `A_ENTRY_KIND) begin
            hrdata = {30'h0, r.kind};
        end else if (r.a_addr == `A_INFO_BASE) begin
            hrdata = r.info_base;
        end else if (r.a_addr == `A_VP_TAG) begin
            hrdata = {16'h0000, r.vp};
        end else if (r.a_addr == `A_PC_TAG) begin
            hrdata = {20'h00000, r.pc};
        end else if (r.a_addr == `A_STATUS) begin
            hrdata = {27'h0, r.stale, r.outcome, r.state != ST_IDLE};
        end else if (r.a_addr == `A_EXIT_REASON) begin
            hrdata = r.exit_reason;
        end else if (r.a_addr == `A_EXIT_LEN) begin
            hrdata = {28'h0000000, r.exit_len};
        end else if (r.a_addr == `A_PTR_INDEX) begin
            hrdata = {16'h0000, r.ptr_index};
        end else begin
            hrdata = 32'h00000000;
        end
    end

    // ********
    // Outputs
    // ********
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign ud_fault = r.pulse.ud;
    assign vm_exit = r.pulse.exit;
    assign ve_fault = r.pulse.ve;
    // R17: fault vector
    assign ve_vector = `VE_VECTOR;
    assign tlb_inval = r.pulse.inval;
    assign base_walk = r.pulse.walk;
    assign resume_next = r.pulse.resume;
    // R11: mapping tags
    assign tag_frame = r.root[`FRAME_HI:`FRAME_LO];
    // R13: disabled tag values
    assign tag_vp = r.opt.virtual_processor_tag_en ? r.vp : `VP_NONE;
    assign tag_pc = r.opt.process_context_tag_en ? r.pc : `PC_NONE;

    // ********
    // Assertions
    // ********
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence s_fn_go;
        ce && cmd_fn && !g_ud && !g_off && (r.selector == `SEL_SWITCH);
    endsequence
    sequence s_marked;
        ce && (r.state == ST_WR_MARK) && mem_rsp.ack;
    endsequence

    property p_ud;
        ce && cmd_fn && g_ud |=> ud_fault && !vm_exit;
    endproperty
    a_ud: assert property (p_ud) else $error("fault not raised"); // R1
    property p_gate31;
        ce && cmd_fn && !r.prim[`PRIM_SEC_BIT] |=> ud_fault;
    endproperty
    a_gate31: assert property (p_gate31) else $error("disabled gate ignored"); // R3
    property p_bound;
        s_fn_go and (r.index >= `LIST_LEN) |=> vm_exit && (r.state == ST_IDLE) && !mem_req.req;
    endproperty
    a_bound: assert property (p_bound) else $error("index bound missed"); // R4
    property p_fetch;
        s_fn_go and (r.index < `LIST_LEN) |=> (r.state == ST_RD_LO)
            && (mem_req.addr == r.list_base + (r.index << `ENTRY_SHIFT));
    endproperty
    a_fetch: assert property (p_fetch) else $error("fetch address wrong"); // R5
    property p_bad_ptr;
        ce && (r.state == ST_CHECK) && !g_ok |=> vm_exit && $stable(r.root)
            && (r.exit_reason == `EXIT_GUEST_FUNCTION_INSTR);
    endproperty
    a_bad_ptr: assert property (p_bad_ptr) else $error("bad pointer accepted"); // R6
    property p_good_ptr;
        ce && (r.state == ST_CHECK) && g_ok |=> (r.root == $past(r.tent)) && resume_next && !vm_exit;
    endproperty
    a_good_ptr: assert property (p_good_ptr) else $error("switch not installed"); // R7
    property p_inval;
        ce && (r.state == ST_CHECK) && g_ok |=> tlb_inval == !$past(r.opt.virtual_processor_tag_en);
    endproperty
    a_inval: assert property (p_inval) else $error("invalidate wrong"); // R12
    property p_no_conv;
        ce && cmd_vio && !r.opt.ve_ctrl && !j_misconf |=> vm_exit && (r.exit_reason == `EXIT_VIOL);
    endproperty
    a_no_conv: assert property (p_no_conv) else $error("violation not exited"); // R18
    property p_ve;
        s_marked |=> ve_fault && (r.state == ST_IDLE);
    endproperty
    a_ve: assert property (p_ve) else $error("fault not delivered after marker"); // R24
endmodule

// ---- tb/mem_model.sv ----
// Memory model on the block's memory port.
// Assumes one request at a time, held until ack.
module mem_model (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic slow,
    input wire gts_pkg::mem_req_t mem_req,
    output gts_pkg::mem_rsp_t mem_rsp
);
    timeunit 1ns;
    timeprecision 1ps;
    import gts_pkg::*;
    logic [31:0] mem [0:63];
    logic [1:0] wait_reg;
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mem_rsp <= '0;
            wait_reg <= 2'h0;
        end else if (mem_req.req && !mem_rsp.ack && wait_reg >= {slow, 1'h0}) begin
            mem_rsp <= {1'h1, mem[mem_req.addr[7:2]]};
            wait_reg <= 2'h0;
            if (mem_req.we) mem[mem_req.addr[7:2]] <= mem_req.wdata;
        end else begin
            mem_rsp <= {1'h0, ~mem_rsp.rdata};
            wait_reg <= wait_reg + {1'h0, mem_req.req};
        end
    end
endmodule

// ---- tb/tb_top.sv ----
// Bench for the guest table switch block.
// Assumes the memory model on the memory port.
`include "gts_consts.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import gts_pkg::*;
    logic hclk = 1'h0, hresetn = 1'h0, hsel = 1'h0, hwrite = 1'h0, slow = 1'h0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rdv;
    logic hreadyout, hresp, ud_fault, vm_exit, ve_fault, tlb_inval, base_walk, resume_next;
    logic [7:0] ve_vector;
    logic [39:0] tag_frame;
    logic [15:0] tag_vp;
    logic [11:0] tag_pc;
    logic [5:0] p;
    mem_req_t mem_req;
    mem_rsp_t mem_rsp;
    int num_errors = 0, compares = 0, reads = 0, r;
    always #2 hclk = ~hclk;
    always @(posedge hclk) if (mem_req.req) reads++;
    guest_table_switch_fault guest_table_switch_fault_inst (.hclk, .hresetn, .ce(1'h1), .hsel,
        .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hresp,
        .hrdata, .mem_req, .mem_rsp, .ud_fault, .vm_exit, .ve_fault, .ve_vector, .tlb_inval,
        .base_walk, .resume_next, .tag_frame, .tag_vp, .tag_pc);
    mem_model mem_model_inst (.hclk, .hresetn, .slow, .mem_req, .mem_rsp);
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic end_of_test();
        if (num_errors == 0 && compares > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic rdy();
        for (int n = 0; n == 0 || hreadyout !== 1'h1; n++) begin
            if (n > 8) chk(1'h0, 1'h1);
            if (n > 8) end_of_test();
            @(posedge hclk);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        {hsel, htrans, haddr, hwrite} <= {1'h1, 2'h2, 24'h0, a, w};
        rdy();
        {htrans, hwdata} <= {2'h0, d};
        rdy();
        rdv = hrdata;
    endtask
    task automatic run(input logic [31:0] cmd, input logic [5:0] exp);
        bus(1'h1, `A_CMD, cmd);
        p = 6'h0;
        for (int n = 0; n < 40 && p === 6'h0; n++) begin
            #1;
            p = {ud_fault, vm_exit, ve_fault, resume_next, tlb_inval, base_walk};
            if (p === 6'h0) @(posedge hclk);
        end
        chk(p, exp);
        if (p === 6'h0) end_of_test();
    endtask
    task automatic t_gate();
        bus(1'h1, `A_SEC, 32'h00002000);
        bus(1'h1, `A_FUNC_LO, 32'h00000001);
        run(32'h1, 6'h20);
        bus(1'h1, `A_PRIM, 32'h80000000);
        bus(1'h1, `A_SELECTOR, 32'h00000040);
        run(32'h1, 6'h20);
        bus(1'h1, `A_SELECTOR, 32'h0000003f);
        bus(1'h1, `A_ILEN, 32'h00000005);
        run(32'h1, 6'h10);
        bus(1'h0, `A_EXIT_REASON, 32'h0);
        chk(rdv, `EXIT_GUEST_FUNCTION_INSTR);
        bus(1'h0, `A_EXIT_LEN, 32'h0);
        chk(rdv, 32'h5);
    endtask
    task automatic t_switch();
        mem_model_inst.mem[2] = 32'hf012305e;
        mem_model_inst.mem[3] = 32'h000abcde;
        mem_model_inst.mem[4] = 32'h00000007;
        bus(1'h1, `A_SELECTOR, 32'h0);
        bus(1'h1, `A_OPT, 32'h0000010e);
        bus(1'h1, `A_VP_TAG, 32'h00001234);
        bus(1'h1, `A_PC_TAG, 32'h00000abc);
        bus(1'h1, `A_INDEX, 32'h00000200);
        r = reads;
        run(32'h1, 6'h10);
        chk(reads, r);
        bus(1'h1, `A_INDEX, 32'h00000002);
        run(32'h1, 6'h10);
        bus(1'h1, `A_INDEX, 32'h00000001);
        bus(1'h1, `A_FUNC_LO, 32'h0);
        run(32'h1, 6'h10);
        bus(1'h1, `A_FUNC_LO, 32'h00000001);
        slow = 1'h1;
        run(32'h1, 6'h07);
        bus(1'h0, `A_ROOT_LO, 32'h0);
        chk(rdv, 32'hf012305e);
        bus(1'h0, `A_PTR_INDEX, 32'h0);
        chk(rdv, 32'h1);
        chk(tag_frame, 40'habcdef0123);
        chk({tag_vp, tag_pc}, 28'h0);
        bus(1'h1, `A_OPT, 32'h000001af);
        run(32'h1, 6'h04);
        chk({tag_vp, tag_pc}, 28'h1234abc);
        mem_model_inst.mem[6] = 32'hf012301e;
        mem_model_inst.mem[7] = 32'h000abcde;
        bus(1'h1, `A_INDEX, 32'h00000003);
        run(32'h1, 6'h04);
        bus(1'h1, `A_INDEX, 32'h00000001);
        run(32'h1, 6'h04);
        bus(1'h0, `A_STATUS, 32'h0);
        chk(rdv, 32'h16);
    endtask
    task automatic t_fault();
        mem_model_inst.mem[33] = 32'h0;
        bus(1'h1, `A_INFO_BASE, 32'h00000080);
        bus(1'h1, `A_ENTRY_LO, 32'h0);
        bus(1'h1, `A_ENTRY_HI, 32'h0);
        bus(1'h1, `A_ENTRY_KIND, 32'h0);
        bus(1'h1, `A_OPT, 32'h0000010e);
        run(32'h2, 6'h08);
        chk(ve_vector, `VE_VECTOR);
        chk({mem_model_inst.mem[32], mem_model_inst.mem[33]}, {`EXIT_VIOL, `INFO_MARK});
        chk(mem_model_inst.mem[40], 32'h1);
        run(32'h2, 6'h10);
        mem_model_inst.mem[33] = 32'h0;
        bus(1'h1, `A_OPT, 32'h0000011e);
        run(32'h2, 6'h10);
        bus(1'h1, `A_OPT, 32'h0000010c);
        run(32'h2, 6'h10);
        bus(1'h1, `A_OPT, 32'h0000010a);
        run(32'h2, 6'h10);
        bus(1'h1, `A_OPT, 32'h00000106);
        run(32'h2, 6'h10);
        bus(1'h1, `A_OPT, 32'h0000010e);
        bus(1'h1, `A_ENTRY_HI, 32'h80000000);
        run(32'h2, 6'h10);
        chk(mem_model_inst.mem[33], 32'h0);
        bus(1'h1, `A_ENTRY_LO, 32'h00000007);
        bus(1'h1, `A_ENTRY_KIND, 32'h00000002);
        run(32'h2, 6'h10);
        bus(1'h1, `A_ENTRY_HI, 32'h0);
        bus(1'h1, `A_ENTRY_KIND, 32'h00000001);
        run(32'h2, 6'h08);
    endtask
    initial begin
        repeat (5) @(posedge hclk);
        hresetn <= 1'h1;
        t_gate();
        t_switch();
        t_fault();
        end_of_test();
    end
endmodule
